// ### src/scg_pkg.sv
`default_nettype none

package scg_pkg;

	// ****************************************
	// Register offsets on the serial port
	// ****************************************
	localparam logic [14:0] ADDR_STAGE_BIAS   = 15'h0100;
	localparam logic [14:0] ADDR_MUTE_MASK    = 15'h0101;
	localparam logic [14:0] ADDR_ON_MASK      = 15'h0102;
	localparam logic [14:0] ADDR_UNLOCK_MUTE  = 15'h0103;
	localparam logic [14:0] ADDR_INT_LOW      = 15'h0200;
	localparam logic [14:0] ADDR_INT_HIGH     = 15'h0201;
	localparam logic [14:0] ADDR_REF_DIVIDER  = 15'h020C;
	localparam logic [14:0] ADDR_REF_CONTROL  = 15'h020E;

	// ****************************************
	// Reset values and field positions
	// ****************************************
	localparam logic [7:0] RST_STAGE_BIAS  = 8'hDF;
	localparam logic [7:0] RST_MUTE_MASK   = 8'hBF;
	localparam logic [7:0] RST_ON_MASK     = 8'hFF;
	localparam logic       RST_UNLOCK_MUTE = 1'b1;
	localparam logic [7:0] RST_INT_LOW     = 8'h90;
	localparam logic [7:0] RST_INT_HIGH    = 8'h01;
	localparam logic [7:0] RST_REF_DIVIDER = 8'h01;
	localparam logic [7:0] RST_REF_CONTROL = 8'h04;
	localparam int unsigned UNLOCK_MUTE_BIT     = 0;
	localparam int unsigned REF_HALVE_ENABLE_BIT = 0;
	localparam int unsigned REF_DOUBLER_BIT     = 3;

	// ****************************************
	// Serial frame layout and timing
	// ****************************************
	localparam logic [4:0] SPI_INSTR_LAST = 5'd15;
	localparam logic [4:0] SPI_DATA_FIRST = 5'd16;
	localparam logic [4:0] SPI_FRAME_LAST = 5'd23;
	localparam logic [4:0] SPI_FRAME_BITS = 5'd24;
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned CAL_TIME_NS   = 10000;
	localparam int unsigned CAL_CYCLES_DEFAULT =
		(CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed
	{
		logic        read;
		logic [14:0] addr;
		logic [7:0]  data;
	} scg_access_type;

	typedef struct packed
	{
		logic [15:0] feedback_integer;
		logic [7:0]  reference_divider;
		logic [7:0]  reference_control;
	} scg_synth_cfg_type;

	typedef enum logic [2:0]
	{
		CAL_IDLE = 3'b001,
		CAL_TUNE = 3'b010,
		CAL_LOCK = 3'b100
	} scg_cal_state_type;

endpackage : scg_pkg

`default_nettype wire

// ### src/scg_serial_port.sv
`default_nettype none

module scg_serial_port
(
	input  wire logic                    clk,
	input  wire logic                    rst,
	input  wire logic                    sclk_pin,
	input  wire logic                    sdi_pin,
	input  wire logic                    cs_n_pin,
	input  wire logic [7:0]              rd_data,
	output var  scg_pkg::scg_access_type access,
	output logic                         write_stb,
	output logic                         read_stb,
	output logic                         sdo,
	output logic                         sdo_oe
);

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// The serial clock is oversampled, so it must run below an eighth of clk.
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic [2:0] sync_c;
	logic [2:0] pin_f;
	logic [2:0] pin_prev;
	logic [4:0] bit_count;
	logic [7:0] out_shift;
	logic       cs_low;
	logic       rise;
	logic       fall;

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_sync
			always_ff @(posedge clk)
			begin
				if (rst)
				begin
					sync_a[g] <= (g == 2);
					sync_b[g] <= (g == 2);
					sync_c[g] <= (g == 2);
					pin_f[g]  <= (g == 2);
				end
				else
				begin
					sync_a[g] <= (g == 0) ? sclk_pin : ((g == 1) ? sdi_pin : cs_n_pin);
					sync_b[g] <= sync_a[g];
					sync_c[g] <= sync_b[g];
					if (sync_b[g] == sync_c[g])
					begin
						pin_f[g] <= sync_c[g];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			pin_prev <= 3'b100;
		end
		else
		begin
			pin_prev <= pin_f;
		end
	end

	assign cs_low = ~pin_f[2];
	assign rise   = cs_low & pin_f[0] & ~pin_prev[0];
	assign fall   = cs_low & ~pin_f[0] & pin_prev[0];

	// ****************************************
	// Frame capture
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst || !cs_low)
		begin
			bit_count <= 5'd0;
		end
		else if (rise && bit_count != scg_pkg::SPI_FRAME_BITS)
		begin
			bit_count <= bit_count + 5'd1;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			access <= '0;
		end
		else if (rise)
		begin
			if (bit_count == 5'd0)
			begin
				access.read <= pin_f[1];
			end
			else if (bit_count <= scg_pkg::SPI_INSTR_LAST)
			begin
				access.addr[4'(bit_count - 5'd1)] <= pin_f[1];
			end
			else if (bit_count <= scg_pkg::SPI_FRAME_LAST)
			begin
				access.data[3'(bit_count - scg_pkg::SPI_DATA_FIRST)] <= pin_f[1];
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			write_stb <= 1'b0;
			read_stb  <= 1'b0;
		end
		else
		begin
			write_stb <= rise && bit_count == scg_pkg::SPI_FRAME_LAST && !access.read;
			read_stb  <= rise && bit_count == scg_pkg::SPI_INSTR_LAST && access.read;
		end
	end

	// ****************************************
	// Read data, LSB first on falling edges
	// ****************************************
	always_ff @(posedge clk)
	begin
		if (rst || !cs_low)
		begin
			out_shift <= 8'h00;
			sdo       <= 1'b0;
			sdo_oe    <= 1'b0;
		end
		else if (read_stb)
		begin
			out_shift <= rd_data;
			sdo_oe    <= 1'b1;
		end
		else if (fall && sdo_oe)
		begin
			sdo       <= out_shift[0];
			out_shift <= {1'b0, out_shift[7:1]};
		end
	end

endmodule : scg_serial_port

`default_nettype wire

// ### src/scg_synth_control.sv
`default_nettype none

module scg_synth_control
#(
	parameter int unsigned CAL_CYCLES = scg_pkg::CAL_CYCLES_DEFAULT
)
(
	input  wire logic                        CORE_CLK,
	input  wire logic                        RST,
	input  wire logic                        SPI_SCLK,
	input  wire logic                        SPI_SDI,
	input  wire logic                        SPI_CS_N,
	output logic                             SPI_SDO,
	output logic                             SPI_SDO_OE,
	input  wire logic                        TX_MUTE_PIN,
	input  wire logic                        TRANSMIT_ON_PIN,
	input  wire logic                        PLL_LOCKED,
	output logic [7:0]                       STAGE_ON,
	output var  scg_pkg::scg_synth_cfg_type  SYNTH_CFG,
	output logic                             CAL_START,
	output logic                             CAL_RUN,
	output logic                             LOCK_RUN
);

	// The counter is 16 bits wide and a zero-length run would wrap to a 65536-cycle tune.
	if (CAL_CYCLES < 1 || CAL_CYCLES > 65535)
	begin : g_bad_cal_cycles
		$error("CAL_CYCLES must lie between 1 and 65535");
	end

	scg_pkg::scg_access_type    access;
	scg_pkg::scg_cal_state_type cal_state;
	logic        write_stb;
	logic        read_stb;
	logic [7:0]  rd_data;
	logic [7:0]  stage_bias;
	logic [7:0]  mute_mask;
	logic [7:0]  on_mask;
	logic        unlock_mute;
	logic [7:0]  int_low;
	logic [7:0]  int_high;
	logic [7:0]  ref_divider;
	logic [7:0]  ref_control;
	logic        commit;
	logic [15:0] cal_count;
	logic [2:0]  sync_a;
	logic [2:0]  sync_b;
	logic [2:0]  sync_c;
	logic [2:0]  pin_f;
	logic        mute_cond;
	logic [7:0]  blocked;
	logic [7:0]  next_stage_on;

	scg_serial_port u_serial
	(
		.clk       (CORE_CLK),
		.rst       (RST),
		.sclk_pin  (SPI_SCLK),
		.sdi_pin   (SPI_SDI),
		.cs_n_pin  (SPI_CS_N),
		.rd_data   (rd_data),
		.access    (access),
		.write_stb (write_stb),
		.read_stb  (read_stb),
		.sdo       (SPI_SDO),
		.sdo_oe    (SPI_SDO_OE)
	);

	// ****************************************
	// Register writes
	// ****************************************
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			stage_bias  <= scg_pkg::RST_STAGE_BIAS;
			mute_mask   <= scg_pkg::RST_MUTE_MASK;
			on_mask     <= scg_pkg::RST_ON_MASK;
			unlock_mute <= scg_pkg::RST_UNLOCK_MUTE;
			int_low     <= scg_pkg::RST_INT_LOW;
			int_high    <= scg_pkg::RST_INT_HIGH;
			ref_divider <= scg_pkg::RST_REF_DIVIDER;
			ref_control <= scg_pkg::RST_REF_CONTROL;
		end
		else if (write_stb)
		begin
			case (access.addr)
				scg_pkg::ADDR_STAGE_BIAS:  stage_bias  <= access.data;
				scg_pkg::ADDR_MUTE_MASK:   mute_mask   <= access.data;
				scg_pkg::ADDR_ON_MASK:     on_mask     <= access.data;
				scg_pkg::ADDR_UNLOCK_MUTE:
					unlock_mute <= access.data[scg_pkg::UNLOCK_MUTE_BIT];
				scg_pkg::ADDR_INT_LOW:     int_low     <= access.data;
				scg_pkg::ADDR_INT_HIGH:    int_high    <= access.data;
				scg_pkg::ADDR_REF_DIVIDER: ref_divider <= access.data;
				scg_pkg::ADDR_REF_CONTROL: ref_control <= access.data;
				default:
				begin
				end
			endcase
		end
	end

	// Reads return the written (pending) values; unmapped addresses read zero.
	always_comb
	begin
		case (access.addr)
			scg_pkg::ADDR_STAGE_BIAS:  rd_data = stage_bias;
			scg_pkg::ADDR_MUTE_MASK:   rd_data = mute_mask;
			scg_pkg::ADDR_ON_MASK:     rd_data = on_mask;
			scg_pkg::ADDR_UNLOCK_MUTE: rd_data = {7'h00, unlock_mute};
			scg_pkg::ADDR_INT_LOW:     rd_data = int_low;
			scg_pkg::ADDR_INT_HIGH:    rd_data = int_high;
			scg_pkg::ADDR_REF_DIVIDER: rd_data = ref_divider;
			scg_pkg::ADDR_REF_CONTROL: rd_data = ref_control;
			default:                   rd_data = 8'h00;
		endcase
	end

	// ****************************************
	// Double-buffer commit
	// ****************************************
	assign commit = write_stb && access.addr == scg_pkg::ADDR_INT_LOW;

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			SYNTH_CFG <= '{feedback_integer: {scg_pkg::RST_INT_HIGH, scg_pkg::RST_INT_LOW},
				reference_divider: scg_pkg::RST_REF_DIVIDER,
				reference_control: scg_pkg::RST_REF_CONTROL};
		end
		else if (commit)
		begin
			SYNTH_CFG <= '{feedback_integer: {int_high, access.data},
				reference_divider: ref_divider,
				reference_control: ref_control};
		end
	end

	// ****************************************
	// Calibration then lock sequence
	// ****************************************
	// A new commit restarts calibration even mid-sequence, so the loop never
	// settles on a stale divider.
	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			cal_state <= scg_pkg::CAL_IDLE;
			cal_count <= 16'h0000;
			CAL_START <= 1'b0;
		end
		else
		begin
			CAL_START <= commit;
			if (commit)
			begin
				cal_state <= scg_pkg::CAL_TUNE;
				cal_count <= 16'(CAL_CYCLES - 1);
			end
			else
			begin
				case (cal_state)
					scg_pkg::CAL_IDLE:
					begin
					end
					scg_pkg::CAL_TUNE:
					begin
						if (cal_count == 16'h0000)
						begin
							cal_state <= scg_pkg::CAL_LOCK;
						end
						else
						begin
							cal_count <= cal_count - 16'h0001;
						end
					end
					scg_pkg::CAL_LOCK:
					begin
						if (pin_f[2])
						begin
							cal_state <= scg_pkg::CAL_IDLE;
						end
					end
					default:
					begin
						cal_state <= scg_pkg::CAL_IDLE;
					end
				endcase
			end
		end
	end

	assign CAL_RUN  = cal_state[1];
	assign LOCK_RUN = cal_state[2];

	// ****************************************
	// Stage gating
	// ****************************************
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_sync
			always_ff @(posedge CORE_CLK)
			begin
				if (RST)
				begin
					sync_a[g] <= 1'b0;
					sync_b[g] <= 1'b0;
					sync_c[g] <= 1'b0;
					pin_f[g]  <= 1'b0;
				end
				else
				begin
					sync_a[g] <= (g == 0) ? TX_MUTE_PIN : ((g == 1) ? TRANSMIT_ON_PIN : PLL_LOCKED);
					sync_b[g] <= sync_a[g];
					sync_c[g] <= sync_b[g];
					if (sync_b[g] == sync_c[g])
					begin
						pin_f[g] <= sync_c[g];
					end
				end
			end
		end
	endgenerate

	assign mute_cond = pin_f[0] | (unlock_mute & ~pin_f[2]);
	assign blocked   = {8{mute_cond}} & mute_mask;

	generate
		for (g = 0; g < 8; g++)
		begin : g_stage
			assign next_stage_on[g] = !blocked[g] && stage_bias[g]
				&& (!on_mask[g] || pin_f[1]);
		end
	endgenerate

	always_ff @(posedge CORE_CLK)
	begin
		if (RST)
		begin
			STAGE_ON <= 8'h00;
		end
		else
		begin
			STAGE_ON <= next_stage_on;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	property p_commit_starts_cal;
		@(posedge CORE_CLK) disable iff (RST)
		commit |=> CAL_START && CAL_RUN ##1 !CAL_START;
	endproperty
	a_commit_starts_cal: assert property (p_commit_starts_cal)
		else $error("Low byte write did not start calibration");

	property p_pending_held;
		@(posedge CORE_CLK) disable iff (RST)
		write_stb && (access.addr == scg_pkg::ADDR_INT_HIGH
			|| access.addr == scg_pkg::ADDR_REF_DIVIDER
			|| access.addr == scg_pkg::ADDR_REF_CONTROL) |=> $stable(SYNTH_CFG);
	endproperty
	a_pending_held: assert property (p_pending_held)
		else $error("Pending register took effect early");

	property p_atomic_commit;
		@(posedge CORE_CLK) disable iff (RST)
		commit |=> SYNTH_CFG == {$past(int_high), $past(access.data),
			$past(ref_divider), $past(ref_control)};
	endproperty
	a_atomic_commit: assert property (p_atomic_commit)
		else $error("Commit did not copy all pending values");

	property p_mute_forces_off;
		@(posedge CORE_CLK) disable iff (RST)
		mute_cond |=> (STAGE_ON & $past(mute_mask)) == 8'h00;
	endproperty
	a_mute_forces_off: assert property (p_mute_forces_off)
		else $error("Muted stage was left on");

	property p_unmuted_path;
		@(posedge CORE_CLK) disable iff (RST)
		!mute_cond |=> STAGE_ON == $past(stage_bias & (~on_mask | {8{pin_f[1]}}));
	endproperty
	a_unmuted_path: assert property (p_unmuted_path)
		else $error("Unmuted stage did not follow transmit-on path");

	property p_unmasked_follows_bias;
		@(posedge CORE_CLK) disable iff (RST)
		!$past(RST) |-> ((STAGE_ON ^ $past(stage_bias)) & ~$past(on_mask)
			& ~$past(blocked)) == 8'h00;
	endproperty
	a_unmasked_follows_bias: assert property (p_unmasked_follows_bias)
		else $error("Stage with on mask 0 did not follow bias");

	property p_masked_needs_pin;
		@(posedge CORE_CLK) disable iff (RST)
		!$past(RST) |-> (STAGE_ON & $past(on_mask)) ==
			($past(on_mask & ~blocked & stage_bias) & {8{$past(pin_f[1])}});
	endproperty
	a_masked_needs_pin: assert property (p_masked_needs_pin)
		else $error("Stage with on mask 1 ignored transmit-on pin");

	property p_unlock_mutes;
		@(posedge CORE_CLK) disable iff (RST)
		unlock_mute && !pin_f[2] |=> (STAGE_ON & $past(mute_mask)) == 8'h00;
	endproperty
	a_unlock_mutes: assert property (p_unlock_mutes)
		else $error("Unlock did not mute masked stages");

	property p_bias_off;
		@(posedge CORE_CLK) disable iff (RST)
		!$past(RST) |-> (STAGE_ON & ~$past(stage_bias)) == 8'h00;
	endproperty
	a_bias_off: assert property (p_bias_off)
		else $error("Stage on with bias disabled");

	property p_stage_independent;
		@(posedge CORE_CLK) disable iff (RST)
		!$past(RST) && $stable(stage_bias) && $stable(on_mask) && $stable(blocked)
			&& $stable(pin_f[1]) |=> $stable(STAGE_ON);
	endproperty
	a_stage_independent: assert property (p_stage_independent)
		else $error("Stage changed without a change of its inputs");

	c_commit: cover property (@(posedge CORE_CLK) disable iff (RST)
		commit ##1 CAL_RUN ##[1:300] LOCK_RUN);
	c_mute: cover property (@(posedge CORE_CLK) disable iff (RST)
		mute_cond && mute_mask != 8'h00);
	c_read: cover property (@(posedge CORE_CLK) disable iff (RST) read_stb);

endmodule : scg_synth_control

`default_nettype wire

// ### verification/scg_host_model.sv
`default_nettype none

module scg_host_model
(
	input  wire logic clk,
	input  wire logic sdo,
	input  wire logic sdo_oe,
	output logic      sclk,
	output logic      sdi,
	output logic      cs_n
);
	timeunit 1ns;
	timeprecision 1ps;

	// A third of a serial period in core cycles (the clock high time); the port synchroniser needs at least two.
	localparam int HALF = 8;

	initial
	begin
		sclk = 1'b0;
		sdi  = 1'b0;
		cs_n = 1'b1;
	end

	// ****************************************
	// One serial frame, possibly cut short
	// ****************************************
	// The clock stands low between frames and the data line shows the inverse of its last
	// bit, so a stale bit can never pass for a fresh one.
	task automatic frame(input logic rd, input logic [14:0] addr, input logic [7:0] data,
		input int nbits, output logic [7:0] q);
		logic [23:0] bits;
		bits = {data, addr, rd};
		q = 8'h00;
		@(posedge clk);
		cs_n <= 1'b0;
		for (int i = 0; i < nbits; i++)
		begin
			repeat (HALF) @(posedge clk);
			sdi <= bits[i];
			repeat (HALF) @(posedge clk);
			if (i >= 16)
				q[i - 16] = sdo_oe ? sdo : 1'bx;
			sclk <= 1'b1;
			repeat (HALF) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (HALF) @(posedge clk);
		cs_n <= 1'b1;
		sdi  <= ~sdi;
		repeat (HALF) @(posedge clk);
	endtask : frame

endmodule : scg_host_model

`default_nettype wire

// ### verification/tb.sv
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int CAL_CYC = 4;

	typedef struct packed
	{
		logic       mpin;
		logic       ub;
		logic       lock;
		logic       tx;
		logic [7:0] bias;
		logic [7:0] mm;
		logic [7:0] om;
		logic [7:0] exp;
	} scg_row_type;

	logic                       clk;
	logic                       rst;
	logic                       mute_pin;
	logic                       transmit_on_pin_pin;
	logic                       locked;
	logic                       sclk;
	logic                       sdi;
	logic                       cs_n;
	logic                       sdo;
	logic                       sdo_oe;
	logic [7:0]                 stage_on;
	scg_pkg::scg_synth_cfg_type cfg;
	scg_pkg::scg_synth_cfg_type cfg_at_start;
	logic                       cal_start;
	logic                       cal_run;
	logic                       lock_run;
	logic [7:0]                 q;
	int                         err_count;
	int                         checked;
	int                         starts;
	int                         s0;
	int                         cal_len;

	scg_row_type rows [7] = '{
		'{1'b0, 1'b0, 1'b1, 1'b0, 8'hA5, 8'hFF, 8'h0F, 8'hA0},
		'{1'b0, 1'b0, 1'b1, 1'b1, 8'hA5, 8'hFF, 8'h0F, 8'hA5},
		'{1'b1, 1'b0, 1'b1, 1'b1, 8'hFF, 8'h3C, 8'h00, 8'hC3},
		'{1'b0, 1'b1, 1'b0, 1'b1, 8'hFF, 8'h0F, 8'h00, 8'hF0},
		'{1'b0, 1'b0, 1'b0, 1'b1, 8'hFF, 8'h0F, 8'h00, 8'hFF},
		'{1'b1, 1'b1, 1'b0, 1'b0, 8'h5A, 8'h81, 8'h66, 8'h18},
		'{1'b0, 1'b1, 1'b1, 1'b0, 8'h3C, 8'hFF, 8'h30, 8'h0C}};
	logic [14:0] init_a [10] = '{15'h0000, 15'h0000, 15'h0103, 15'h022B, 15'h022F,
		15'h030A, 15'h0309, 15'h030D, 15'h030E, 15'h0300};
	logic [7:0]  init_d [10] = '{8'h99, 8'h18, 8'h00, 8'h0B, 8'h27, 8'h00, 8'h88, 8'h09,
		8'h09, 8'h1F};
	logic [14:0] reg_a [8] = '{scg_pkg::ADDR_STAGE_BIAS, scg_pkg::ADDR_MUTE_MASK,
		scg_pkg::ADDR_ON_MASK, scg_pkg::ADDR_UNLOCK_MUTE, scg_pkg::ADDR_INT_LOW,
		scg_pkg::ADDR_INT_HIGH, scg_pkg::ADDR_REF_DIVIDER, scg_pkg::ADDR_REF_CONTROL};
	logic [7:0]  reg_d [8] = '{8'hDF, 8'hBF, 8'hFF, 8'h01, 8'h90, 8'h01, 8'h01, 8'h04};

	scg_host_model host (.clk(clk), .sdo(sdo), .sdo_oe(sdo_oe), .sclk(sclk), .sdi(sdi),
		.cs_n(cs_n));

	scg_synth_control #(.CAL_CYCLES(CAL_CYC)) uut
	(
		.CORE_CLK        (clk),
		.RST             (rst),
		.SPI_SCLK        (sclk),
		.SPI_SDI         (sdi),
		.SPI_CS_N        (cs_n),
		.SPI_SDO         (sdo),
		.SPI_SDO_OE      (sdo_oe),
		.TX_MUTE_PIN     (mute_pin),
		.TRANSMIT_ON_PIN (transmit_on_pin_pin),
		.PLL_LOCKED      (locked),
		.STAGE_ON        (stage_on),
		.SYNTH_CFG       (cfg),
		.CAL_START       (cal_start),
		.CAL_RUN         (cal_run),
		.LOCK_RUN        (lock_run)
	);

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Counts commits and the length of each calibration run as the design reports them.
	always @(posedge clk)
	begin
		if (cal_start === 1'b1)
		begin
			starts++;
			cfg_at_start = cfg;
			cal_len = 1;
		end
		else if (cal_run === 1'b1)
			cal_len++;
	end

	// ****************************************
	// Compare, access and closing tasks
	// ****************************************
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string m);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk8

	task automatic chkcfg(input scg_pkg::scg_synth_cfg_type got,
		input scg_pkg::scg_synth_cfg_type exp, input string m);
		checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chkcfg

	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		host.frame(1'b0, a, d, 24, q);
		repeat (4) @(posedge clk);
	endtask : wr

	task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
		host.frame(1'b1, a, 8'h00, 24, q);
		chk8(q, e, "read data");
		chk8({7'h00, sdo_oe}, 8'h00, "data out released");
	endtask : rd_chk

	task automatic results;
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results

	// The tests take about 35000 cycles; the limit leaves ample margin.
	initial
	begin
		repeat (80000) @(posedge clk);
		err_count++;
		results();
	end

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		rst = 1'b1;
		mute_pin = 1'b0;
		transmit_on_pin_pin = 1'b0;
		locked = 1'b1;
		repeat (20) @(posedge clk);
		chk8(stage_on, 8'h00, "stage on in reset");
		chkcfg(cfg, '{16'h0190, 8'h01, 8'h04}, "config in reset");
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		for (int i = 0; i < 8; i++)
			rd_chk(reg_a[i], reg_d[i]);
		$display("test reset done");

		for (int i = 0; i < 10; i++)
			wr(init_a[i], init_d[i]);
		rd_chk(scg_pkg::ADDR_UNLOCK_MUTE, 8'h00);
		rd_chk(15'h0300, 8'h00);
		$display("test init done");

		for (int i = 0; i < 7; i++)
		begin
			wr(scg_pkg::ADDR_STAGE_BIAS, rows[i].bias);
			wr(scg_pkg::ADDR_MUTE_MASK, rows[i].mm);
			wr(scg_pkg::ADDR_ON_MASK, rows[i].om);
			wr(scg_pkg::ADDR_UNLOCK_MUTE, {7'h7F, rows[i].ub});
			mute_pin <= rows[i].mpin;
			transmit_on_pin_pin <= rows[i].tx;
			locked <= rows[i].lock;
			repeat (12) @(posedge clk);
			chk8(stage_on, rows[i].exp, "stage gating");
		end
		rd_chk(scg_pkg::ADDR_UNLOCK_MUTE, 8'h01);
		$display("test gating done");

		// host order for the buffered set
		locked <= 1'b1;
		s0 = starts;
		wr(scg_pkg::ADDR_REF_DIVIDER, 8'h05);
		wr(scg_pkg::ADDR_REF_CONTROL, 8'h09);
		wr(scg_pkg::ADDR_INT_HIGH, 8'h02);
		chkcfg(cfg, '{16'h0190, 8'h01, 8'h04}, "pending not applied");
		rd_chk(scg_pkg::ADDR_INT_HIGH, 8'h02);
		chk8(8'(starts - s0), 8'h00, "no commit yet");
		locked <= 1'b0;
		wr(scg_pkg::ADDR_INT_LOW, 8'h34);
		chk8(8'(starts - s0), 8'h01, "one commit");
		chkcfg(cfg_at_start, '{16'h0234, 8'h05, 8'h09}, "atomic commit");
		chkcfg(cfg, '{16'h0234, 8'h05, 8'h09}, "applied set");
		chk8(8'(cal_len), 8'(CAL_CYC), "calibration length");
		chk8({7'h00, lock_run}, 8'h01, "waiting for lock");
		locked <= 1'b1;
		for (int n = 0; n < 20 && lock_run !== 1'b0; n++)
			@(posedge clk);
		chk8({6'h00, cal_run, lock_run}, 8'h00, "idle after lock");
		$display("test commit done");

		s0 = starts;
		host.frame(1'b0, scg_pkg::ADDR_INT_LOW, 8'h77, 20, q);
		repeat (10) @(posedge clk);
		chk8(8'(starts - s0), 8'h00, "short frame commits");
		chkcfg(cfg, '{16'h0234, 8'h05, 8'h09}, "short frame config");
		rd_chk(scg_pkg::ADDR_INT_LOW, 8'h34);
		$display("test short frame done");

		// A second reset in mid-run must bring back the power-up active set.
		rst <= 1'b1;
		repeat (4) @(posedge clk);
		chk8(stage_on, 8'h00, "stage on in second reset");
		chkcfg(cfg, '{16'h0190, 8'h01, 8'h04}, "config in second reset");
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		rd_chk(scg_pkg::ADDR_INT_HIGH, 8'h01);
		chk8({6'h00, cal_run, lock_run}, 8'h00, "idle after second reset");
		$display("test second reset done");
		results();
	end

endmodule : tb

`default_nettype wire
